// [core/ifc_counter.sv]
// intermediate-frequency, period, timer and split event counter
// What this block does
// RULE1 - one 20-bit binary counter steered by a control port
// RULE2 - run written 1 starts, 0 stops; timer start also clears count
// RULE3 - automatic mode counts input edges for the gate time, then stops
// RULE4 - busy stays high while a measurement runs
// RULE5 - overflow set once the count reaches two to the twentieth
// RULE6 - software reads result only with busy and overflow both low
// RULE7 - software gating: gate code not all ones, gate bit and run set
// RULE8 - software-gated count ends when run is written 0
// RULE9 - period mode counts 75 kHz reference over one input cycle
// RULE10 - period select 1 switches input to the period pin
// RULE11 - software keeps gate bits low in period mode
// RULE12 - period busy drops after the closing input edge or a run write of 0
// RULE13 - gate bit and gate code all ones give a free 75 kHz timer
// RULE14 - timer is cleared on each run write of 1
// RULE15 - split and gate bits set give independent 12 and 8 bit counters
// RULE16 - split input a feeds the 12-bit, split input b the 8-bit half
// RULE17 - count bits 0..11 low counter, 12..19 high counter
// RULE18 - each split half clears when its run bit is written 1
// RULE19 - IF amplifier off while the loop is off; others keep working
// RULE20 - logic input source works in every mode regardless of the loop
// RULE21 - reference select all ones turns loop off, suspends IF counting
// RULE22 - one count per rising edge of the synchronised input
`default_nettype none
module ifc_counter (
    input wire logic ref_clk,                      // 25 MHz clock
    input wire logic arst_n,                       // async reset, active low
    input wire ifc_pkg::ifc_cfg_t cfg,             // configuration bits
    input wire ifc_pkg::ifc_run_t run,             // run-bit write strobes
    input wire logic ifInput,                      // IF amplifier output pin
    input wire logic logicInput,                   // general logic input
    input wire logic periodInputPin,               // period measure pin
    input wire logic splitInputA,                  // split counter pin a
    input wire logic splitInputB,                  // split counter pin b
    output ifc_pkg::ifc_status_t status,           // busy, overflow, count
    output logic ifAmpEnable,                      // IF amplifier enable
    output logic pllOff                            // loop off indication
);
    import ifc_pkg::*;

    // rising edge of a synchronised lane against its delayed copy
    // lanes and their copies reset low like idle pins: no edge on release
    function automatic logic riseOf(input logic now, input logic last);
        riseOf = now & ~last;
    endfunction

    // gate length in reference ticks for a gate code
    // code 3 lands in default; it only means something as the timer
    function automatic logic [GATE_W-1:0] gateTicks(input logic [1:0] sel);
        case (sel)
            2'h0: gateTicks = GATE_TICKS_0;
            2'h1: gateTicks = GATE_TICKS_1;
            default: gateTicks = GATE_TICKS_2;
        endcase
    endfunction

    // reset release and synchronised pins
    logic rstMeta;
    logic rst_n;
    logic [IN_W-1:0] pinSync;
    logic [IN_W-1:0] pinLast;

    // reference tick generator
    logic [9:0] refAcc;
    logic refTick;
    logic [9:0] refSum;

    // sequencer and gate timer
    ifc_state_t state;
    ifc_state_t next_state;
    logic [GATE_W-1:0] gateLeft;

    // next values of the status register
    logic [CNT_W-1:0] next_count;
    logic next_overflow;

    // decoded modes, input edge and run requests
    logic [1:0] gateSel;
    logic splitOn;
    logic timerOn;
    logic loopOff;
    logic suspended;
    logic selEdge;
    logic startReq;
    logic stopReq;
    logic countStep;

    // reset released through two flops; only constants under reset
    // assertion stays asynchronous, release lands on a clock edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rst_n <= rstMeta;
        end
    end

    // lane order below must match the IDX_ constants of the package
    ifc_sync u_sync (
        .clk(ref_clk),
        .rst_n(rst_n),
        .din({splitInputB, splitInputA, periodInputPin, logicInput,
              ifInput}),
        .dout(pinSync)
    );

    // delayed copy of the synchronised lanes for edge detection
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinLast <= IN_RST;
        end else begin
            pinLast <= pinSync;
        end
    end

    // 75 kHz tick: add 3 per cycle modulo 1000, so no drift accumulates
    // a plain divide by 333 would run fast and drift against the crystal
    assign refSum = refAcc + REF_STEP;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            refAcc <= REF_ACC_RST;
            refTick <= 1'b0;
        end else if (refSum >= REF_MOD) begin
            refAcc <= 10'(refSum - REF_MOD);
            refTick <= 1'b1;
        end else begin
            refAcc <= refSum;
            refTick <= 1'b0;
        end
    end

    // mode decode; split outranks the timer code
    // loop off also stops the other dividers, which sit outside this block
    assign gateSel = {cfg.gateTimeSelHi, cfg.gateTimeSelLo};
    assign splitOn = cfg.splitMode & cfg.manualGate;              // RULE15
    assign timerOn = cfg.manualGate & (gateSel == GATE_TIMER)
                     & ~splitOn;                                  // RULE13
    assign loopOff = (cfg.refSelect == REF_SEL_OFF);              // RULE21
    // only the IF path stalls with the loop off; logic input keeps going
    assign suspended = loopOff & cfg.sourceSelectBit
                       & ~cfg.periodInputSelect;                  // RULE20

    // selected counter input edge
    // the period pin outranks the source select bit
    always_comb begin
        if (cfg.periodInputSelect) begin                          // RULE10
            selEdge = riseOf(pinSync[IDX_PERIOD], pinLast[IDX_PERIOD]);
        end else if (cfg.sourceSelectBit) begin
            // amplifier gated off with the loop
            selEdge = riseOf(pinSync[IDX_IF], pinLast[IDX_IF])
                      & ~loopOff;                                 // RULE19
        end else begin
            selEdge = riseOf(pinSync[IDX_LOGIC], pinLast[IDX_LOGIC]);
        end
    end

    // run writes reach the sequencer only outside split mode
    assign startReq = run.runWr & run.runData & ~splitOn;         // RULE2
    assign stopReq = run.runWr & ~run.runData & ~splitOn;         // RULE2

    // measurement sequencer
    // a start always wins, so a run write of 1 restarts any measurement
    // split entry parks it in idle so busy reads 0 in split mode
    // a suspended IF count freezes the gate timer with it
    always_comb begin
        next_state = state;
        if (startReq) begin
            if (timerOn || cfg.manualGate) begin
                next_state = IFC_FREE;                            // RULE7
            end else if (cfg.periodInputSelect) begin
                next_state = IFC_WAIT_EDGE;                       // RULE11
            end else begin
                next_state = IFC_GATE;                            // RULE3
            end
        end else if (stopReq || splitOn) begin
            next_state = IFC_IDLE;                                // RULE8
        end else if (!suspended) begin
            case (state)
                IFC_IDLE: next_state = IFC_IDLE;
                IFC_GATE: begin
                    if (refTick && gateLeft <= 10'h001) begin
                        next_state = IFC_IDLE;                    // RULE3
                    end
                end
                IFC_WAIT_EDGE: begin
                    // the first edge opens the period window
                    if (selEdge) begin
                        next_state = IFC_PERIOD;                  // RULE9
                    end
                end
                IFC_PERIOD: begin
                    // busy holds until the closing edge arrives
                    if (selEdge) begin
                        next_state = IFC_IDLE;                    // RULE12
                    end
                end
                // free runs until a stop write or split entry
                IFC_FREE: next_state = IFC_FREE;
                default: next_state = IFC_IDLE;
            endcase
        end
    end

    // sequencer state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= IFC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // gate time down-counter in reference ticks
    // reloaded on every start, so a new gate code applies at once
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gateLeft <= GATE_RST;
        end else if (startReq) begin
            gateLeft <= gateTicks(gateSel);
        end else if (state == IFC_GATE && refTick && !suspended) begin
            gateLeft <= 10'(gateLeft - 10'h001);
        end
    end

    // what advances the 20-bit counter this cycle
    // the free state counts reference ticks as a timer, input edges else
    always_comb begin
        case (state)
            IFC_GATE: countStep = selEdge;                        // RULE22
            IFC_PERIOD: countStep = refTick;                      // RULE9
            IFC_FREE: countStep = timerOn ? refTick : selEdge;    // RULE13
            default: countStep = 1'b0;
        endcase
        countStep = countStep & ~suspended;                       // RULE21
    end

    // count and overflow; a start clears both, then counting resumes
    // overflow is sticky until the next start while the count wraps on
    always_comb begin
        next_count = status.count;
        next_overflow = status.overflow;
        if (splitOn) begin
            // two independent halves, each with its own run bit
            // a half counts while its last written run data is 1
            if (run.runWr && run.runData) begin
                next_count[SPLIT_LO_W-1:0] = 12'h000;             // RULE18
            end else if (run.runData &&
                         riseOf(pinSync[IDX_SPLIT_A],
                                pinLast[IDX_SPLIT_A])) begin
                next_count[SPLIT_LO_W-1:0] =
                    12'(status.count[SPLIT_LO_W-1:0] + 12'h001);  // RULE16
            end
            if (run.runAltWr && run.runAltData) begin
                next_count[CNT_W-1:SPLIT_LO_W] = 8'h00;           // RULE18
            end else if (run.runAltData &&
                         riseOf(pinSync[IDX_SPLIT_B],
                                pinLast[IDX_SPLIT_B])) begin
                next_count[CNT_W-1:SPLIT_LO_W] =
                    8'(status.count[CNT_W-1:SPLIT_LO_W] + 8'h01); // RULE17
            end
        end else if (startReq) begin
            next_count = CNT_RST;                                 // RULE14
            next_overflow = 1'b0;
        end else if (countStep) begin
            next_count = 20'(status.count + 20'h00001);           // RULE1
            if (status.count == 20'hFFFFF) begin
                next_overflow = 1'b1;                             // RULE5
            end
        end
    end

    // status register; one process owns every field of the status port
    // busy follows the next state, so it rises with the start edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status.busy <= 1'b0;
            status.count <= CNT_RST;
            status.overflow <= 1'b0;
        end else begin
            status.busy <= (next_state != IFC_IDLE);              // RULE4
            status.count <= next_count;
            status.overflow <= next_overflow;
        end
    end

    // amplifier enable and loop-off indication from flops
    // flops keep decode glitches off the pins that leave the block
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ifAmpEnable <= 1'b0;
            pllOff <= 1'b0;
        end else begin
            ifAmpEnable <= ~loopOff & cfg.sourceSelectBit;        // RULE19
            pllOff <= loopOff;                                    // RULE21
        end
    end
endmodule
`default_nettype wire

// [core/ifc_pkg.sv]
// constants, types and carriers of the intermediate-frequency counter
`default_nettype none
package ifc_pkg;
    // clock and the 75 kHz reference, made by a fractional accumulator
    localparam int CLK_HZ = 25_000_000;
    localparam int REF_HZ = 75_000;
    localparam int REF_GCD_HZ = 25_000;
    localparam logic [9:0] REF_STEP = 10'(REF_HZ / REF_GCD_HZ);
    localparam logic [9:0] REF_MOD = 10'(CLK_HZ / REF_GCD_HZ);
    localparam logic [9:0] REF_ACC_RST = 10'h000;

    // counter geometry
    localparam int CNT_W = 20;
    localparam int SPLIT_LO_W = 12;
    localparam int SPLIT_HI_W = 8;
    localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;

    // gate times in microseconds for gate codes 0..2, code 3 is the timer
    localparam int GATE_US_0 = 1000;
    localparam int GATE_US_1 = 4000;
    localparam int GATE_US_2 = 8000;
    localparam int GATE_W = 10;
    localparam logic [GATE_W-1:0] GATE_TICKS_0 =
        GATE_W'(GATE_US_0 * (REF_HZ / 1000) / 1000);
    localparam logic [GATE_W-1:0] GATE_TICKS_1 =
        GATE_W'(GATE_US_1 * (REF_HZ / 1000) / 1000);
    localparam logic [GATE_W-1:0] GATE_TICKS_2 =
        GATE_W'(GATE_US_2 * (REF_HZ / 1000) / 1000);
    localparam logic [GATE_W-1:0] GATE_RST = 10'h000;
    localparam logic [1:0] GATE_TIMER = 2'h3;

    // reference select port width; all ones means the loop is off
    localparam int REF_SEL_W = 3;
    localparam logic [REF_SEL_W-1:0] REF_SEL_OFF = 3'h7;

    // synchronised pin lanes
    localparam int IN_W = 5;
    localparam int IDX_IF = 0;
    localparam int IDX_LOGIC = 1;
    localparam int IDX_PERIOD = 2;
    localparam int IDX_SPLIT_A = 3;
    localparam int IDX_SPLIT_B = 4;
    localparam logic [IN_W-1:0] IN_RST = 5'h00;

    typedef enum logic [2:0] {
        IFC_IDLE = 3'b000,
        IFC_GATE = 3'b001,
        IFC_WAIT_EDGE = 3'b010,
        IFC_PERIOD = 3'b011,
        IFC_FREE = 3'b100
    } ifc_state_t;

    // configuration bits written by software
    typedef struct packed {
        logic sourceSelectBit;               // 1 = IF pin, 0 = logic input
        logic periodInputSelect;             // 1 = period input pin
        logic gateTimeSelHi;
        logic gateTimeSelLo;
        logic manualGate;                    // software-gate bit
        logic splitMode;
        logic [REF_SEL_W-1:0] refSelect;
    } ifc_cfg_t;

    // run-bit write strobes with their data
    typedef struct packed {
        logic runWr;                         // write to count_run_bit
        logic runData;
        logic runAltWr;                      // write to count_run_bit_alt
        logic runAltData;
    } ifc_run_t;

    // status read back by software
    typedef struct packed {
        logic busy;
        logic overflow;
        logic [CNT_W-1:0] count;
    } ifc_status_t;
endpackage
`default_nettype wire

// [core/ifc_sync.sv]
// two-flop synchroniser for the counter's pin inputs
`default_nettype none
module ifc_sync (
    input wire logic clk,                          // counter clock
    input wire logic rst_n,                        // synchronous-release reset
    input wire logic [ifc_pkg::IN_W-1:0] din,      // asynchronous pins
    output logic [ifc_pkg::IN_W-1:0] dout          // synchronised copy
);
    import ifc_pkg::*;

    logic [IN_W-1:0] stage1;

    // first stage feeds only the second, to keep metastability contained
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= IN_RST;
            dout <= IN_RST;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

// [dv/ifc_counter_properties.sv]
// port-level checks of the intermediate-frequency counter
`default_nettype none
module ifc_counter_properties (
    input wire logic ref_clk,                 // counter clock
    input wire logic arst_n,                  // async reset, active low
    input wire ifc_pkg::ifc_cfg_t cfg,        // configuration bits
    input wire ifc_pkg::ifc_run_t run,        // run-bit strobes
    input wire logic ifInput,                 // IF pin
    input wire logic logicInput,              // logic input pin
    input wire logic periodInputPin,          // period pin
    input wire logic splitInputA,             // split pin a
    input wire logic splitInputB,             // split pin b
    input wire ifc_pkg::ifc_status_t status,  // busy, overflow, count
    input wire logic ifAmpEnable,             // amplifier enable
    input wire logic pllOff                   // loop off flag
);
    timeunit 1ns;
    timeprecision 1ns;
    import ifc_pkg::*;
    logic [2:0] up;
    logic pinQ;
    logic [3:0] sincePin;
    logic split;
    assign split = cfg.splitMode & cfg.manualGate;
    // outputs sit at zero just after release, so wait those edges out
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            up <= 3'h0;
        else if (up != 3'h5)
            up <= up + 3'h1;
    end
    // age of the last rising edge on the period pin, saturating
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinQ <= 1'b0;
            sincePin <= 4'hF;
        end else begin
            pinQ <= periodInputPin;
            if (periodInputPin && !pinQ)
                sincePin <= 4'h0;
            else if (sincePin != 4'hF)
                sincePin <= sincePin + 4'h1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence startReq;
        up == 3'h5 && run.runWr && run.runData && !split;
    endsequence
    sequence freshCount;
        status.busy && !status.overflow && status.count == CNT_RST;
    endsequence
    start_clear_a: assert property (startReq |=> freshCount)
        else $error("start did not clear the count");
    stop_write_a: assert property
        (up == 3'h5 && run.runWr && !run.runData && !split |=> !status.busy)
        else $error("stop did not end the measurement");
    split_low_a: assert property
        (up == 3'h5 && split && run.runWr && run.runData
         |=> status.count[11:0] == 12'h000)
        else $error("low half not cleared");
    split_high_a: assert property
        (up == 3'h5 && split && run.runAltWr && run.runAltData
         |=> status.count[19:12] == 8'h00)
        else $error("high half not cleared");
    count_step_a: assert property
        (up == 3'h5 && !run.runWr && !split
         |=> status.count == $past(status.count)
          || status.count == 20'($past(status.count) + 20'h00001))
        else $error("count moved by more than one");
    overflow_wrap_a: assert property
        ($rose(status.overflow) |-> status.count == CNT_RST
         && $past(status.count) == 20'hFFFFF)
        else $error("overflow without wrap");
    period_end_a: assert property
        (up == 3'h5 && $fell(status.busy) && cfg.periodInputSelect
         && !$past(run.runWr) |-> sincePin <= 4'h8)
        else $error("period ended without input edge");
    pll_off_a: assert property
        (up == 3'h5 |-> pllOff == $past(cfg.refSelect == REF_SEL_OFF))
        else $error("loop off flag wrong");
    amp_enable_a: assert property
        (up == 3'h5 |-> ifAmpEnable == $past(cfg.refSelect != REF_SEL_OFF
         && cfg.sourceSelectBit))
        else $error("amplifier enable wrong");
endmodule
`default_nettype wire

// [dv/ifc_pulse_src.sv]
// pulse source standing in for the tuner and logic-level pins
`default_nettype none
module ifc_pulse_src (
    input wire logic clk,                      // counter clock
    input wire logic go,                       // start a burst
    input wire logic [2:0] lane,               // pin to toggle
    input wire logic [7:0] nPulses,            // rising edges to send
    input wire logic [15:0] halfPer,           // half period in cycles
    output var logic [ifc_pkg::IN_W-1:0] pins, // logic-level pins
    output logic done                          // burst finished
);
    timeunit 1ns;
    timeprecision 1ns;
    import ifc_pkg::*;
    int left = 0;
    int cnt = 0;
    initial pins = IN_RST;
    // pins move on the falling edge, clear of the counter's sampling
    always @(negedge clk) begin
        if (go) begin
            left = 2 * int'(nPulses);
            cnt = int'(halfPer);
        end else if (left > 0) begin
            cnt = cnt - 1;
            if (cnt == 0) begin
                pins[lane] = ~pins[lane];
                left = left - 1;
                cnt = int'(halfPer);
            end
        end
    end
    assign done = (left == 0);
endmodule
`default_nettype wire

// [dv/ifc_counter_bench.sv]
// self-checking bench of the intermediate-frequency counter
`default_nettype none
module ifc_counter_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import ifc_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    ifc_cfg_t cfg = '0;
    ifc_run_t run = '0;
    logic go = 1'b0;
    logic [2:0] lane = 3'h0;
    logic [7:0] nPulses = 8'h00;
    logic [15:0] halfPer = 16'h0001;
    logic [IN_W-1:0] pins;
    logic srcDone;
    ifc_status_t status;
    logic chk = 1'b0;
    ifc_status_t expQ[$];
    int miscompares = 0;
    int checked = 0;
    logic [31:0] seed = 32'h61A2E2A1;
    int n;
    int m;
    ifc_counter u_ifc_counter (.ref_clk(ref_clk), .arst_n(arst_n),
        .cfg(cfg), .run(run), .ifInput(pins[IDX_IF]),
        .logicInput(pins[IDX_LOGIC]), .periodInputPin(pins[IDX_PERIOD]),
        .splitInputA(pins[IDX_SPLIT_A]), .splitInputB(pins[IDX_SPLIT_B]),
        .status(status), .ifAmpEnable(), .pllOff());
    ifc_pulse_src u_ifc_pulse_src (.clk(ref_clk), .go(go), .lane(lane),
        .nPulses(nPulses), .halfPer(halfPer), .pins(pins), .done(srcDone));
    // 25 MHz clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    function int rnd(input int lim);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return int'(seed % 32'(lim));
    endfunction
    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    // one-cycle strobe; the data level stays, split halves count on it
    task automatic wr_run(input logic alt, input logic d);
        @(negedge ref_clk);
        if (alt) begin
            run.runAltWr <= 1'b1;
            run.runAltData <= d;
        end else begin
            run.runWr <= 1'b1;
            run.runData <= d;
        end
        @(negedge ref_clk);
        run.runWr <= 1'b0;
        run.runAltWr <= 1'b0;
    endtask
    task automatic burst(input int ln, input int k, input int hp);
        int w;
        w = 0;
        @(negedge ref_clk);
        lane <= 3'(ln);
        nPulses <= 8'(k);
        halfPer <= 16'(hp);
        go <= 1'b1;
        @(negedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        while (srcDone !== 1'b1 && w < 40000) begin
            @(posedge ref_clk);
            w++;
        end
        tick(8); // let synchroniser and edge detect settle
    endtask
    task automatic wait_idle();
        int w;
        w = 0;
        while (status.busy !== 1'b0 && w < 40000) begin
            @(posedge ref_clk);
            w++;
        end
    endtask
    task automatic note(input logic b, input logic [CNT_W-1:0] c);
        expQ.push_back({b, 1'b0, c});
        @(negedge ref_clk);
        chk <= 1'b1;
        @(negedge ref_clk);
        chk <= 1'b0;
    endtask
    task automatic cmp_stat(input ifc_status_t e, input ifc_status_t s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] status expected %h seen %h", e, s);
        end
    endtask
    // monitor: each flagged cycle takes the oldest note
    always @(posedge ref_clk) begin
        if (chk === 1'b1 && expQ.size() > 0)
            cmp_stat(expQ.pop_front(), status);
    end
    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog: the tests need some 60000 cycles
    initial begin
        #(40 * 100000);
        miscompares++;
        test_done();
    end
    initial begin
        cfg.sourceSelectBit = 1'b1;
        tick(4);
        arst_n <= 1'b1;
        tick(4);
        // automatic gate: all edges fall inside the 1 ms gate
        n = 20 + rnd(30);
        wr_run(1'b0, 1'b1);
        burst(IDX_IF, n, 3 + rnd(4));
        note(1'b1, 20'(n));
        wait_idle();
        note(1'b0, 20'(n));
        $display("test auto done");
        // software gate under each gate code short of the timer
        cfg.manualGate <= 1'b1;
        for (int g = 0; g < 3; g++) begin
            {cfg.gateTimeSelHi, cfg.gateTimeSelLo} <= 2'(g);
            n = 1 + rnd(60);
            wr_run(1'b0, 1'b1);
            burst(IDX_IF, n, 2 + rnd(4));
            wr_run(1'b0, 1'b0);
            note(1'b0, 20'(n));
        end
        $display("test manual done");
        // timer over 10000 cycles sees 30 reference ticks
        {cfg.gateTimeSelHi, cfg.gateTimeSelLo} <= GATE_TIMER;
        wr_run(1'b0, 1'b1);
        tick(9998);
        wr_run(1'b0, 1'b0);
        note(1'b0, 20'h0001E);
        $display("test timer done");
        // one 10000-cycle input period gives 30 reference ticks
        cfg.manualGate <= 1'b0;
        {cfg.gateTimeSelHi, cfg.gateTimeSelLo} <= 2'h0;
        cfg.periodInputSelect <= 1'b1;
        wr_run(1'b0, 1'b1);
        burst(IDX_PERIOD, 2, 5000);
        note(1'b0, 20'h0001E);
        $display("test period done");
        // loop off: IF edges are lost, the logic input still counts
        cfg.periodInputSelect <= 1'b0;
        cfg.manualGate <= 1'b1;
        cfg.refSelect <= REF_SEL_OFF;
        wr_run(1'b0, 1'b1);
        burst(IDX_IF, 10, 2);
        wr_run(1'b0, 1'b0);
        note(1'b0, 20'h00000);
        cfg.sourceSelectBit <= 1'b0;
        n = 1 + rnd(60);
        wr_run(1'b0, 1'b1);
        burst(IDX_LOGIC, n, 2 + rnd(4));
        wr_run(1'b0, 1'b0);
        note(1'b0, 20'(n));
        $display("test loop off done");
        // split: pin a fills bits 11..0, pin b bits 19..12
        cfg.refSelect <= 3'h0;
        cfg.splitMode <= 1'b1;
        wr_run(1'b0, 1'b1);
        wr_run(1'b1, 1'b1);
        n = 1 + rnd(200);
        m = 1 + rnd(200);
        burst(IDX_SPLIT_A, n, 2);
        burst(IDX_SPLIT_B, m, 2);
        note(1'b0, {8'(m), 12'(n)});
        wr_run(1'b0, 1'b1);
        note(1'b0, {8'(m), 12'h000});
        wr_run(1'b1, 1'b1);
        note(1'b0, 20'h00000);
        $display("test split done");
        test_done();
    end
endmodule
bind ifc_counter ifc_counter_properties u_ifc_counter_properties (
    .ref_clk(ref_clk), .arst_n(arst_n), .cfg(cfg), .run(run),
    .ifInput(ifInput), .logicInput(logicInput),
    .periodInputPin(periodInputPin), .splitInputA(splitInputA),
    .splitInputB(splitInputB), .status(status),
    .ifAmpEnable(ifAmpEnable), .pllOff(pllOff));
`default_nettype wire
